// ===== rtl/fss_top.sv
// Fault response, NVM thermal guard and sync oversight for two channels
//
// Function
// RULE1: Each fault line selects which of OV, UV, OC, OT, timing, peak OC report.
// RULE2: A fault line pulled low by another party counts as a fault.
// RULE3: Per channel response: ignore, shut down and latch, or shut down and retry.
// RULE4: Output overvoltage forces that channel's switch node low, always.
// RULE5: With logging on, a fault that shuts a channel down stores log data.
// RULE6: Peak values sit in the log header and can be read any time.
// RULE7: Block NVM above 130 C until die temperature falls below 120 C.
// RULE8: Own sync output holds the line low for 500 ns each cycle.
// RULE9: Timebase line runs at 10 us period, low 1 us each period.
// RULE10: Internal oscillator locks to sync falling edge, edge-sensitive, no harmonics.
// RULE11: Channel phase after sync fall comes from low 3 bits of phase setup.
// RULE12: Software should space multiphase channels evenly.
// RULE13: Lock is guaranteed for sync between 200 kHz and 1 MHz.
// RULE14: Lock lost in operation sets status bit 4 and pulls alert low.
// RULE15: Writing one to status bit 4 clears it.
// RULE16: Masked lock-loss fault does not assert alert.
// RULE17: Without sync clock, switching runs at the nominal programmed period.
// RULE18: Idle sync line reads as bit 10 low in pad readback.
// RULE19: Only one device on a shared sync line drives it.
// RULE20: On-time under minimum skips cycles but keeps regulating.
// RULE21: Bit 5 of operating setup selects the remote temperature method.
// RULE22: Remote sensor reading returns through the paged temperature read.
// RULE23: Retry starts a timer at shutdown, re-enables on expiry, repeats on recurrence.
`timescale 1ns/1ps
`default_nettype none
module fss_top
    import fss_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Fault detectors, bit0 OV, then UV, OC, OT, timing, peak OC
    input  wire logic [5:0]  fault_ev0,
    input  wire logic [5:0]  fault_ev1,
    // Shared fault lines (open drain)
    input  wire logic [1:0]  fault_in,
    output logic [1:0]       fault_out,
    output logic [1:0]       fault_oe,
    // Sync line (open drain)
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic             sync_oe,
    // Timebase line (open drain)
    output logic             tb_out,
    output logic             tb_oe,
    // Alert line (open drain)
    output logic             alert_out,
    output logic             alert_oe,
    // Power stage control
    input  wire logic [7:0]  on_req0,
    input  wire logic [7:0]  on_req1,
    output logic [1:0]       chan_en,
    output logic [1:0]       switch_node_n_low,
    output logic [1:0]       pwm_hi,
    // Temperature
    input  wire logic [7:0]  die_temp,
    input  wire logic [11:0] remote_temp_input0,
    input  wire logic [11:0] remote_temp_input1,
    output logic             temp_method,
    output logic             nvm_block
);
    // Registers written by software
    logic        log_en_r, sync_en_r, page_r;
    logic [13:0] fsrc_r;
    logic [3:0]  fresp_r;
    logic [15:0] retry_wait_interval_r;
    logic [2:0]  pwm_phase_setup_r;
    logic        mode_r;
    logic [7:0]  nomp_r;
    logic        amask_r;
    logic        lock_lost_r;
    // Pin synchronisers
    logic [1:0]  flt_q1, flt_q2;
    logic [3:0]  own_oe_r;
    logic        syn_q1, syn_q2, syn_d;
    // Sync tracking
    logic [7:0]  per_cnt_r, meas_r, osc_r, per;
    logic        locked_r, clocking_r, fall;
    logic [7:0]  sync_cnt_r, tb_cnt_r, tick_cnt_r;
    logic        tick;
    // Channel state
    fss_ch_e     st_r [2];
    logic [15:0] tmr_r [2];
    logic [8:0]  acc_r [2];
    logic [8:0]  hi_r [2];
    logic [5:0]  fev [2];
    logic [7:0]  onr [2];
    logic [1:0]  hit, ext_low, rsp_wr;
    logic [13:0] log_r;
    logic [11:0] peak0_r, peak1_r;
    // APB decode
    logic        acc_ph, wr_en, rd_ok;
    logic [31:0] rd_mux;

    assign fev[0] = fault_ev0;
    assign fev[1] = fault_ev1;
    assign onr[0] = on_req0;
    assign onr[1] = on_req1;

    // Offset of a channel's start point inside the switching period
    function automatic logic [7:0] phase_off(input logic [7:0] p, input logic [2:0] c, input logic ch);
        logic [10:0] a;
        logic [8:0]  s;
        a = p * c;
        s = {1'b0, a[10:3]} + (ch ? {2'b0, p[7:1]} : 9'h000);
        if (s >= {1'b0, p}) begin
            s = s - {1'b0, p};
        end
        return s[7:0];
    endfunction

    // APB: one wait state, answer on the second access cycle
    assign acc_ph = psel & penable;
    assign wr_en  = acc_ph & pready & pwrite;
    assign rsp_wr = {wr_en && paddr == OFS_FRESP, wr_en && paddr == OFS_FRESP};

    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            OFS_CTRL:  rd_mux = {29'h0, page_r, sync_en_r, log_en_r};
            OFS_FSRC:  rd_mux = {18'h0, fsrc_r};
            OFS_FRESP: rd_mux = {28'h0, fresp_r};
            OFS_RETRY: rd_mux = {16'h0, retry_wait_interval_r};
            OFS_PHASE: rd_mux = {29'h0, pwm_phase_setup_r};
            OFS_MODE:  rd_mux = {26'h0, mode_r, 5'h0};
            OFS_NOMP:  rd_mux = {24'h0, nomp_r};
            OFS_VSTAT: rd_mux = {27'h0, lock_lost_r, 4'h0};
            OFS_AMASK: rd_mux = {27'h0, amask_r, 4'h0};
            OFS_PADS:  rd_mux = {21'h0, clocking_r, 7'h0, syn_q2, flt_q2};
            OFS_LOG:   rd_mux = {18'h0, log_r};
            OFS_PEAK:  rd_mux = {4'h0, peak1_r, 4'h0, peak0_r}; // [RULE6]
            OFS_TEMP:  rd_mux = {20'h0, page_r ? remote_temp_input1 : remote_temp_input0}; // [RULE22]
            default:   rd_ok  = 1'b0;
        endcase
    end

    // Bus answer; unmapped addresses answer with pslverr and zero data
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_ph & ~pready;
            prdata  <= (acc_ph & ~pready & ~pwrite & rd_ok) ? rd_mux : 32'h0;
            pslverr <= acc_ph & ~pready & ~rd_ok;
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            log_en_r              <= 1'b0;
            sync_en_r             <= 1'b0;
            page_r                <= 1'b0;
            fsrc_r                <= 14'h0;
            fresp_r               <= 4'h0;
            retry_wait_interval_r <= RETRY_RST;
            pwm_phase_setup_r     <= 3'h0;
            mode_r                <= 1'b0;
            nomp_r                <= NOMP_RST;
            amask_r               <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                OFS_CTRL: begin
                    log_en_r  <= pwdata[B_LOG_EN];
                    sync_en_r <= pwdata[B_SYNC_EN];
                    page_r    <= pwdata[B_PAGE];
                end
                OFS_FSRC:  fsrc_r <= pwdata[13:0]; // [RULE1]
                OFS_FRESP: fresp_r <= pwdata[3:0];
                OFS_RETRY: retry_wait_interval_r <= pwdata[15:0];
                OFS_PHASE: pwm_phase_setup_r <= pwdata[2:0]; // [RULE11]
                OFS_MODE:  mode_r <= pwdata[B_TMETH]; // [RULE21]
                OFS_NOMP:  nomp_r <= pwdata[7:0];
                OFS_AMASK: amask_r <= pwdata[B_LOCK];
                default: begin
                end
            endcase
        end
    end

    // Two-flop synchronisers for the shared pins
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flt_q1 <= 2'h3;
            flt_q2 <= 2'h3;
            syn_q1 <= 1'b1;
            syn_q2 <= 1'b1;
            syn_d  <= 1'b1;
            own_oe_r <= 4'h0;
        end else begin
            flt_q1 <= fault_in;
            flt_q2 <= flt_q1;
            syn_q1 <= sync_in;
            syn_q2 <= syn_q1;
            syn_d  <= syn_q2;
            own_oe_r <= {own_oe_r[1:0], fault_oe};
        end
    end
    assign fall = syn_d & ~syn_q2; // [RULE10]

    // Sync period measurement and lock detect; only full periods count, so harmonics never lock
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            per_cnt_r  <= 8'h0;
            meas_r     <= NOMP_RST;
            locked_r   <= 1'b0;
            clocking_r <= 1'b0;
        end else if (fall) begin
            per_cnt_r  <= 8'h1;
            meas_r     <= per_cnt_r;
            clocking_r <= 1'b1;
            locked_r   <= per_cnt_r >= 8'(PER_MIN_CYC) && per_cnt_r <= 8'(PER_MAX_CYC); // [RULE13]
        end else if (per_cnt_r >= 8'(IDLE_CYC)) begin
            clocking_r <= 1'b0; // [RULE18]
            locked_r   <= 1'b0;
        end else begin
            per_cnt_r <= per_cnt_r + 8'h1;
        end
    end

    // Lock loss flag: a new loss wins over a clearing write in the same cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lock_lost_r <= 1'b0;
        end else if (locked_r && ((fall && !(per_cnt_r >= 8'(PER_MIN_CYC) && per_cnt_r <= 8'(PER_MAX_CYC)))
                     || (!fall && per_cnt_r >= 8'(IDLE_CYC)))) begin
            lock_lost_r <= 1'b1; // [RULE14]
        end else if (wr_en && paddr == OFS_VSTAT && pwdata[B_LOCK]) begin
            lock_lost_r <= 1'b0; // [RULE15]
        end
    end

    // Alert line follows the unmasked flag
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            alert_oe <= 1'b0;
        end else begin
            alert_oe <= lock_lost_r & ~amask_r; // [RULE14] [RULE16]
        end
    end
    assign alert_out = 1'b0;

    // Internal oscillator: measured period when locked and own sync drive is off, else nominal
    assign per = (locked_r && !sync_en_r) ? meas_r : nomp_r; // [RULE17]
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            osc_r <= 8'h0;
        end else if (fall && locked_r && !sync_en_r) begin
            osc_r <= 8'h1; // [RULE10]
        end else if (osc_r + 8'h1 >= per) begin
            osc_r <= 8'h0;
        end else begin
            osc_r <= osc_r + 8'h1;
        end
    end

    // Own sync drive; the driver never resyncs to its own edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_cnt_r <= 8'h0;
            sync_oe    <= 1'b0;
        end else if (sync_en_r && osc_r == 8'h0) begin
            sync_cnt_r <= 8'(SYNC_LOW_CYC - 1);
            sync_oe    <= 1'b1;
        end else if (sync_cnt_r != 8'h0) begin
            sync_cnt_r <= sync_cnt_r - 8'h1;
        end else begin
            sync_oe    <= 1'b0; // [RULE8]
        end
    end
    assign sync_out = 1'b0;

    // Timebase line and microsecond tick for the retry timers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tb_cnt_r   <= 8'(TB_PER_CYC - 1);
            tb_oe      <= 1'b0;
            tick_cnt_r <= 8'h0;
            tick       <= 1'b0;
        end else begin
            tb_cnt_r   <= (tb_cnt_r == 8'(TB_PER_CYC - 1)) ? 8'h0 : tb_cnt_r + 8'h1;
            tb_oe      <= (tb_cnt_r == 8'(TB_PER_CYC - 1)) || (tb_cnt_r < 8'(TB_LOW_CYC - 1)); // [RULE9]
            tick_cnt_r <= (tick_cnt_r == 8'(TICK_CYC - 1)) ? 8'h0 : tick_cnt_r + 8'h1;
            tick       <= tick_cnt_r == 8'(TICK_CYC - 1);
        end
    end
    assign tb_out = 1'b0;

    // Fault sources; own drive is excluded so a channel does not trip on itself
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ext_low[c] = ~flt_q2[c] & ~fault_oe[c] & ~own_oe_r[c] & ~own_oe_r[c+2]; // [RULE2]
            hit[c]     = |(fev[c] & fsrc_r[c*8 +: 6]) | ext_low[c]; // [RULE1]
        end
    end

    // Per channel response state machine
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < 2; c++) begin
                st_r[c]  <= ST_RUN;
                tmr_r[c] <= 16'h0;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                case (st_r[c])
                    ST_RUN: begin
                        if (hit[c] && fresp_r[c*2 +: 2] == RSP_LATCH) begin
                            st_r[c] <= ST_LATCH; // [RULE3]
                        end else if (hit[c] && fresp_r[c*2 +: 2] == RSP_RETRY) begin
                            st_r[c]  <= ST_WAIT; // [RULE23]
                            tmr_r[c] <= retry_wait_interval_r;
                        end
                    end
                    ST_LATCH: begin
                        if (rsp_wr[c]) begin
                            st_r[c] <= ST_RUN;
                        end
                    end
                    ST_WAIT: begin
                        if (tick && tmr_r[c] == 16'h0) begin
                            st_r[c] <= ST_RUN; // [RULE23]
                        end else if (tick) begin
                            tmr_r[c] <= tmr_r[c] - 16'h1;
                        end
                    end
                    default: st_r[c] <= ST_RUN;
                endcase
            end
        end
    end

    // Channel enables, fault line drive and OV switch-node clamp
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            chan_en           <= 2'h0;
            fault_oe          <= 2'h0;
            switch_node_n_low <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                chan_en[c]           <= st_r[c] == ST_RUN && !(hit[c] && fresp_r[c*2 +: 2] != RSP_IGN);
                fault_oe[c]          <= st_r[c] != ST_RUN;
                switch_node_n_low[c] <= fev[c][0] | (st_r[c] != ST_RUN); // [RULE4]
            end
        end
    end
    assign fault_out = 2'h0;

    // Fault log capture at shutdown and peak temperatures in the header
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            log_r   <= 14'h0;
            peak0_r <= 12'h0;
            peak1_r <= 12'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (log_en_r && st_r[c] == ST_RUN && hit[c] && fresp_r[c*2 +: 2] != RSP_IGN) begin
                    log_r <= {1'b1, 1'(c), ext_low[c], 5'h0, fev[c] & fsrc_r[c*8 +: 6]}; // [RULE5]
                end
            end
            if (remote_temp_input0 > peak0_r) begin
                peak0_r <= remote_temp_input0; // [RULE6]
            end
            if (remote_temp_input1 > peak1_r) begin
                peak1_r <= remote_temp_input1;
            end
        end
    end

    // Switching starts with on-time accumulation: short pulses are skipped, not lost
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < 2; c++) begin
                acc_r[c] <= 9'h0;
                hi_r[c]  <= 9'h0;
            end
            pwm_hi <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!chan_en[c] || switch_node_n_low[c]) begin
                    acc_r[c] <= 9'h0;
                    hi_r[c]  <= 9'h0;
                end else if (osc_r == phase_off(per, pwm_phase_setup_r, 1'(c))) begin
                    if (acc_r[c] + {1'b0, onr[c]} >= 9'(TON_MIN_CYC)) begin
                        hi_r[c]  <= acc_r[c] + {1'b0, onr[c]};
                        acc_r[c] <= 9'h0;
                    end else begin
                        acc_r[c] <= acc_r[c] + {1'b0, onr[c]}; // [RULE20]
                    end
                end else if (hi_r[c] != 9'h0) begin
                    hi_r[c] <= hi_r[c] - 9'h1;
                end
                pwm_hi[c] <= chan_en[c] && hi_r[c] != 9'h0 && !fev[c][0] && !switch_node_n_low[c];
            end
        end
    end

    // Thermal guard with hysteresis, and sensor method output
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            nvm_block   <= 1'b0;
            temp_method <= 1'b0;
        end else begin
            temp_method <= mode_r; // [RULE21]
            if (die_temp > HOT_C) begin
                nvm_block <= 1'b1; // [RULE7]
            end else if (die_temp < COOL_C) begin
                nvm_block <= 1'b0;
            end
        end
    end

    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_nvm_hot;
        die_temp > HOT_C |=> nvm_block and (die_temp >= COOL_C |=> nvm_block);
    endproperty
    a_nvm_hot: assert property (p_nvm_hot) else $error("NVM not blocked when hot"); // [RULE7]

    property p_sync_low;
        $rose(sync_oe) |-> ##10 $fell(sync_oe);
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("Sync low time wrong"); // [RULE8]

    property p_tb_low;
        $rose(tb_oe) |-> ##20 $fell(tb_oe) ##180 $rose(tb_oe);
    endproperty
    a_tb_low: assert property (p_tb_low) else $error("Timebase shape wrong"); // [RULE9]

    property p_alert;
        lock_lost_r && !amask_r |-> ##1 alert_oe;
    endproperty
    a_alert: assert property (p_alert) else $error("Alert missing on lock loss"); // [RULE14]

    property p_mask;
        amask_r && $stable(amask_r) |-> !alert_oe;
    endproperty
    a_mask: assert property (p_mask) else $error("Masked alert asserted"); // [RULE16]

    property p_w1c;
        lock_lost_r && wr_en && paddr == OFS_VSTAT && pwdata[B_LOCK] && !locked_r |=> !lock_lost_r;
    endproperty
    a_w1c: assert property (p_w1c) else $error("Lock flag not cleared"); // [RULE15]

    property p_ov;
        fault_ev0[0] |=> switch_node_n_low[0] && !pwm_hi[0] ##1 !pwm_hi[0];
    endproperty
    a_ov: assert property (p_ov) else $error("OV did not clamp switch node"); // [RULE4]

    property p_latch;
        st_r[0] == ST_LATCH && !rsp_wr[0] |=> st_r[0] == ST_LATCH ##0 !chan_en[0];
    endproperty
    a_latch: assert property (p_latch) else $error("Latched channel restarted"); // [RULE3]

    property p_idle;
        !fall && per_cnt_r >= 8'(IDLE_CYC) |=> !clocking_r && per == nomp_r;
    endproperty
    a_idle: assert property (p_idle) else $error("Idle sync not reported"); // [RULE18]

    property p_apb;
        acc_ph && !pready |=> pready;
    endproperty
    a_apb: assert property (p_apb) else $error("APB answer late");
endmodule
`default_nettype wire

// ===== shared/fss_pkg.sv
// Constants, register map and types for the fault and sync supervisor
package fss_pkg;
    // Clock and timing
    localparam int unsigned CLK_MHZ      = 20;
    localparam int unsigned SYNC_LOW_NS  = 500;
    localparam int unsigned SYNC_LOW_CYC = (SYNC_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned TB_PER_NS    = 10000;
    localparam int unsigned TB_PER_CYC   = (TB_PER_NS * CLK_MHZ) / 1000;
    localparam int unsigned TB_LOW_NS    = 1000;
    localparam int unsigned TB_LOW_CYC   = (TB_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned TICK_NS      = 1000;
    localparam int unsigned TICK_CYC     = (TICK_NS * CLK_MHZ) / 1000;
    localparam int unsigned TON_MIN_NS   = 90;
    localparam int unsigned TON_MIN_CYC  = (TON_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned FMIN_KHZ     = 200;
    localparam int unsigned FMAX_KHZ     = 1000;
    localparam int unsigned PER_MAX_CYC  = (CLK_MHZ * 1000) / FMIN_KHZ;
    localparam int unsigned PER_MIN_CYC  = (CLK_MHZ * 1000 + FMAX_KHZ - 1) / FMAX_KHZ;
    localparam int unsigned IDLE_CYC     = 2 * PER_MAX_CYC;
    // Die temperature thresholds in degrees C
    localparam logic [7:0] HOT_C  = 8'h82;
    localparam logic [7:0] COOL_C = 8'h78;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_FSRC  = 8'h04;
    localparam logic [7:0] OFS_FRESP = 8'h08;
    localparam logic [7:0] OFS_RETRY = 8'h0c;
    localparam logic [7:0] OFS_PHASE = 8'h10;
    localparam logic [7:0] OFS_MODE  = 8'h14;
    localparam logic [7:0] OFS_NOMP  = 8'h18;
    localparam logic [7:0] OFS_VSTAT = 8'h1c;
    localparam logic [7:0] OFS_AMASK = 8'h20;
    localparam logic [7:0] OFS_PADS  = 8'h24;
    localparam logic [7:0] OFS_LOG   = 8'h28;
    localparam logic [7:0] OFS_PEAK  = 8'h2c;
    localparam logic [7:0] OFS_TEMP  = 8'h30;
    // Field positions
    localparam int unsigned B_LOG_EN  = 0;
    localparam int unsigned B_SYNC_EN = 1;
    localparam int unsigned B_PAGE    = 2;
    localparam int unsigned B_TMETH   = 5;
    localparam int unsigned B_LOCK    = 4;
    localparam int unsigned B_CLKING  = 10;
    // Reset values
    localparam logic [7:0]  NOMP_RST  = 8'h28;
    localparam logic [15:0] RETRY_RST = 16'h0064;
    // Fault responses
    localparam logic [1:0] RSP_IGN   = 2'h0;
    localparam logic [1:0] RSP_LATCH = 2'h1;
    localparam logic [1:0] RSP_RETRY = 2'h2;
    typedef enum logic [1:0] {ST_RUN, ST_LATCH, ST_WAIT} fss_ch_e;
endpackage

// ===== test/fss_peer.sv
// Peer regulator model on the shared sync and fault lines
`timescale 1ns/1ps
`default_nettype none
module fss_peer (
    // Clock, reset and commands
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       sync_run,
    input  wire logic [1:0] fault_pull,
    // Open-drain enables, high pulls the line low
    output logic            sync_oe,
    output logic [1:0]      fault_oe
);
    int cnt;
    // Sole sync driver at 50 cycles (400 kHz); released line floats high on its pull-up
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
            sync_oe <= 1'h0;
        end else begin
            cnt <= (cnt == 49) ? 0 : cnt + 1;
            sync_oe <= sync_run && (cnt < 10);
        end
    end
    // Fault elsewhere in the system pulls the line low
    assign fault_oe = fault_pull;
endmodule
`default_nettype wire

// ===== test/fss_top_tb.sv
// Self-checking bench for the fault and sync supervisor
`timescale 1ns/1ps
`default_nettype none
module fss_top_tb
    import fss_pkg::*;
;
    logic        ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, sync_run = 0;
    logic [7:0]  paddr = 8'h00, die_temp = 8'h19;
    logic [31:0] pwdata = 32'h0, q, n_sync, n_tb;
    logic [5:0]  fault_ev0 = 6'h00, fault_ev1 = 6'h00;
    logic [1:0]  fault_pull = 2'h0;
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, sync_out, sync_oe, p_sync_oe, tb_out, tb_oe, alert_out, alert_oe;
    wire logic   temp_method, nvm_block;
    wire logic [1:0] fault_out, fault_oe, p_fault_oe, chan_en, sw_low, pwm_hi;
    int          num_errors = 0, total_checks = 0, cyc = 0;
    // Open-drain lines resolve from every party's enable
    fss_top i_fss_top (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .fault_ev0, .fault_ev1, .fault_in(~(fault_oe | p_fault_oe)), .fault_out, .fault_oe,
        .sync_in(~(sync_oe | p_sync_oe)), .sync_out, .sync_oe, .tb_out, .tb_oe, .alert_out, .alert_oe,
        .on_req0(8'h01), .on_req1(8'h01), .chan_en, .switch_node_n_low(sw_low), .pwm_hi, .die_temp,
        .remote_temp_input0(12'h123), .remote_temp_input1(12'h5a5), .temp_method, .nvm_block);
    fss_peer i_fss_peer (.ref_clk, .reset, .sync_run, .fault_pull, .sync_oe(p_sync_oe), .fault_oe(p_fault_oe));
    always #25 ref_clk = ~ref_clk;
    // Hang guard, well above the run length
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        apb(1'h1, a, d, e);
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        logic e;
        apb(1'h0, a, 32'h0, e);
    endtask
    task automatic t_regs();
        logic e;
        rd(OFS_NOMP);
        chk("nomp", 32'(NOMP_RST), q);
        rd(OFS_RETRY);
        chk("retry", 32'(RETRY_RST), q);
        wr(OFS_PHASE, 32'h4);
        rd(OFS_PHASE);
        chk("phase", 32'h4, q);
        apb(1'h0, 8'h40, 32'h0, e);
        chk("unmapped err", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, q);
    endtask
    task automatic t_fault();
        logic [1:0] en;
        wr(OFS_CTRL, 32'h1);
        wr(OFS_FSRC, 32'h3f3f);
        wr(OFS_FRESP, 32'h0);
        en = chan_en;
        fault_ev0 <= 6'h01;
        repeat (4) @(posedge ref_clk);
        chk("ov clamp", 32'h1, 32'(sw_low[0]));
        chk("ignore", 32'(en[0]), 32'(chan_en[0]));
        fault_ev0 <= 6'h00;
        wr(OFS_FRESP, 32'h9);
        fault_ev0 <= 6'h04;
        @(posedge ref_clk);
        fault_ev0 <= 6'h00;
        repeat (4) @(posedge ref_clk);
        chk("latch off", 32'h0, 32'(chan_en[0]));
        chk("pwm off", 32'h0, 32'(pwm_hi[0]));
        chk("fault line", 32'h1, 32'(fault_oe[0]));
        rd(OFS_LOG);
        chk("log", 32'h44, 32'({q[13], q[5:0]}));
        repeat (60) @(posedge ref_clk);
        chk("latch hold", 32'h0, 32'(chan_en[0]));
    endtask
    task automatic t_retry();
        wr(OFS_RETRY, 32'h1);
        fault_pull <= 2'h2;
        repeat (3) @(posedge ref_clk);
        fault_pull <= 2'h0;
        repeat (4) @(posedge ref_clk);
        chk("ext fault", 32'h0, 32'(chan_en[1]));
        repeat (60) @(posedge ref_clk);
        chk("retry on", 32'h1, 32'(chan_en[1]));
    endtask
    task automatic t_temp();
        die_temp <= 8'h83;
        repeat (3) @(posedge ref_clk);
        chk("hot", 32'h1, 32'(nvm_block));
        die_temp <= 8'h78;
        repeat (3) @(posedge ref_clk);
        chk("band", 32'h1, 32'(nvm_block));
        die_temp <= 8'h77;
        repeat (3) @(posedge ref_clk);
        chk("cool", 32'h0, 32'(nvm_block));
        wr(OFS_MODE, 32'h20);
        wr(OFS_CTRL, 32'h5);
        chk("method", 32'h1, 32'(temp_method));
        rd(OFS_TEMP);
        chk("temp page", 32'h5a5, q);
        rd(OFS_PEAK);
        chk("peak", 32'h05a50123, q);
    endtask
    task automatic t_sync();
        wr(OFS_CTRL, 32'h1);
        sync_run <= 1'h1;
        repeat (600) @(posedge ref_clk);
        rd(OFS_PADS);
        chk("clocking", 32'h1, 32'(q[10]));
        sync_run <= 1'h0;
        repeat (260) @(posedge ref_clk);
        rd(OFS_PADS);
        chk("idle", 32'h0, 32'(q[10]));
        rd(OFS_VSTAT);
        chk("lock lost", 32'h1, 32'(q[4]));
        chk("alert", 32'h1, 32'(alert_oe));
        wr(OFS_AMASK, 32'h10);
        @(posedge ref_clk);
        chk("masked", 32'h0, 32'(alert_oe));
        wr(OFS_VSTAT, 32'h10);
        rd(OFS_VSTAT);
        chk("cleared", 32'h0, 32'(q[4]));
    endtask
    // Any 200-cycle window holds five sync periods and one timebase period
    task automatic t_drive();
        wr(OFS_CTRL, 32'h3);
        n_sync = 32'h0;
        n_tb = 32'h0;
        repeat (200) begin
            @(posedge ref_clk);
            n_sync += 32'(sync_oe);
            n_tb += 32'(tb_oe);
        end
        chk("sync low", 32'h32, n_sync);
        chk("tb low", 32'h14, n_tb);
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'h0;
        t_regs();
        t_fault();
        t_retry();
        t_temp();
        t_sync();
        t_drive();
        print_verdict();
    end
endmodule
`default_nettype wire
